// [design/pmem_addr.sv]
// Overview of operation
// (RQ1) each program location is one 24-bit instruction word, spanning two addresses
// (RQ2) word splits in 16-bit lower and upper halves; upper top byte unimplemented
// (RQ3) lower half at even address, upper half at next odd; pc aligned
// (RQ4) program counter steps forward or back by two
// (RQ5) addresses below 0x000200 are reserved for vectors, not general code
// (RQ6) after reset fetch at 0x000000 jump; start target word at 0x000002
`timescale 1ns/1ns
`default_nettype none
module pmem_addr
    import pmem_pkg::*;
(
    input wire logic sys_clk,                          // core clock, 100 MHz
    input wire logic nrst,                             // async reset, active low
    input wire pmem_pkg::pc_cmd_t pc_cmd,              // hold, step up, step down, load
    input wire logic [pmem_pkg::pc_w-1:0] pc_target,   // load target
    input wire logic [pmem_pkg::pc_w-1:0] half_addr,   // data-style half access address
    input wire logic prog_en,                          // programming write of one word
    input wire logic [pmem_pkg::pc_w-1:0] prog_addr,   // programming address
    input wire logic [pmem_pkg::instr_w-1:0] prog_data,// programming word
    output logic [pmem_pkg::pc_w-1:0] pc,              // program counter
    output logic [pmem_pkg::instr_w-1:0] instr,        // fetched instruction word
    output logic instr_valid,                          // instr holds the word fetched for the previous cycle's pc
    output logic booting,                              // reset vector sequence active
    output logic [pmem_pkg::half_w-1:0] half_data,     // selected half, registered
    output logic vec_fault                             // run-time code fetch in vector area
);
    import pmem_pkg::*;

    // ********************************
    // helpers
    // ********************************
    // (RQ2) half select
    function automatic logic [half_w-1:0] pick_half(input logic [instr_w-1:0] w,
                                                    input logic odd);
        if (odd) begin
            pick_half = {{(half_w-upper_impl_w){1'b0}}, w[instr_w-1:half_w]};
        end else begin
            pick_half = w[half_w-1:0];
        end
    endfunction

    // (RQ5) vector region
    function automatic logic in_vec(input logic [pc_w-1:0] a);
        in_vec = (a < vec_top);
    endfunction

    // ********************************
    // storage
    // ********************************
    logic [pc_w-1:0] mem_addr;
    logic [instr_w-1:0] rd_word;

    // programming takes the port; otherwise boot reads the vector words, a run hold reads half_addr, and fetch follows the next pc
    pmem_store u_store (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .addr(mem_addr),
        .wr_en(prog_en),
        .wr_data(prog_data),
        .rd_word(rd_word)
    );

    // ********************************
    // program counter and boot
    // ********************************
    boot_state_t st_r, st_nxt;
    logic [pc_w-1:0] pc_nxt;
    logic fetch_r, fetch_nxt;
    logic half_sel_r, half_sel_nxt;
    logic [half_w-1:0] half_nxt;
    logic vec_fault_nxt;
    logic ptr_wait_r, ptr_wait_nxt;

    always_comb begin
        st_nxt = st_r;
        pc_nxt = pc;
        fetch_nxt = 1'b0;
        ptr_wait_nxt = 1'b0;
        half_sel_nxt = half_sel_r;
        mem_addr = pc;
        case (st_r)
            // (RQ6) fetch vector
            st_vec: begin
                mem_addr = reset_vec;
                pc_nxt = start_ptr_addr;
                st_nxt = st_target;
            end
            // (RQ6) take target
            // the pointer word shows one cycle after its address, so this state lasts two cycles
            st_target: begin
                mem_addr = start_ptr_addr;
                if (ptr_wait_r) begin
                    pc_nxt = {8'h00, rd_word[half_w-1:1], 1'b0};
                    st_nxt = st_run;
                end else begin
                    ptr_wait_nxt = 1'b1;
                end
            end
            st_run: begin
                case (pc_cmd)
                    // (RQ4) step by two
                    pc_inc: pc_nxt = pc + pc_step;
                    pc_dec: pc_nxt = pc - pc_step;
                    // (RQ3) force alignment
                    pc_load: pc_nxt = {pc_target[pc_w-1:1], 1'b0};
                    default: pc_nxt = pc;
                endcase
                mem_addr = pc_nxt;
                fetch_nxt = 1'b1;
            end
            default: st_nxt = st_vec;
        endcase
        if (prog_en) begin
            mem_addr = prog_addr;
            fetch_nxt = 1'b0;
        end else if (st_r != st_run || pc_cmd == pc_hold) begin
            half_sel_nxt = half_addr[0];
        end
        if (st_r == st_run && pc_cmd == pc_hold && !prog_en) begin
            mem_addr = half_addr;
            fetch_nxt = 1'b0;
        end
        // (RQ3) odd selects upper
        half_nxt = pick_half(rd_word, half_sel_r);
        // (RQ5) flag vector fetch
        vec_fault_nxt = fetch_nxt && in_vec(pc_nxt);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= st_vec;
            pc <= reset_vec;
            fetch_r <= 1'b0;
            ptr_wait_r <= 1'b0;
            half_sel_r <= 1'b0;
            instr_valid <= 1'b0;
            booting <= 1'b1;
            half_data <= 16'h0000;
            vec_fault <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pc <= pc_nxt;
            fetch_r <= fetch_nxt;
            ptr_wait_r <= ptr_wait_nxt;
            half_sel_r <= half_sel_nxt;
            instr_valid <= fetch_r;
            booting <= (st_nxt != st_run);
            half_data <= half_nxt;
            vec_fault <= vec_fault_nxt;
        end
    end

    // fetched word is registered once more so it lines up with instr_valid
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            instr <= instr_reset;
        end else begin
            instr <= rd_word;
        end
    end

    // ********************************
    // checks
    // ********************************
    // (RQ4) pc step two
    property p_pc_step;
        @(posedge sys_clk) disable iff (!nrst)
        (st_r == st_run && pc_cmd == pc_inc) |=> (pc == $past(pc) + pc_step);
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc did not step by two"); // (RQ4)

    property p_pc_back;
        @(posedge sys_clk) disable iff (!nrst)
        (st_r == st_run && pc_cmd == pc_dec) |=> (pc == $past(pc) - pc_step);
    endproperty
    a_pc_back: assert property (p_pc_back) else $error("pc did not step back by two"); // (RQ4)

    // (RQ3) pc aligned
    property p_pc_even;
        @(posedge sys_clk) disable iff (!nrst)
        st_r == st_run |-> pc[0] == 1'b0;
    endproperty
    a_pc_even: assert property (p_pc_even) else $error("pc is odd"); // (RQ3)

    // (RQ2) upper byte zero
    property p_upper_zero;
        @(posedge sys_clk) disable iff (!nrst)
        half_sel_r |=> half_data[half_w-1:upper_impl_w] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("unimplemented byte nonzero"); // (RQ2)

    // (RQ6) boot order
    property p_boot;
        @(posedge sys_clk) disable iff (!nrst)
        st_r == st_vec |=> st_r == st_target ##1 st_r == st_target ##1 st_r == st_run;
    endproperty
    a_boot: assert property (p_boot) else $error("reset vector sequence broken"); // (RQ6)

    property p_boot_ptr;
        @(posedge sys_clk) disable iff (!nrst)
        st_r == st_target |-> pc == start_ptr_addr;
    endproperty
    a_boot_ptr: assert property (p_boot_ptr) else $error("start pointer not at 0x2"); // (RQ6)

    // (RQ5) vector fault flag
    property p_vec;
        @(posedge sys_clk) disable iff (!nrst)
        (fetch_r && pc < vec_top) |-> vec_fault;
    endproperty
    a_vec: assert property (p_vec) else $error("vector area fetch not flagged"); // (RQ5)

    // (RQ1) fetch latency
    property p_valid;
        @(posedge sys_clk) disable iff (!nrst)
        fetch_nxt |=> ##1 instr_valid;
    endproperty
    a_valid: assert property (p_valid) else $error("fetch valid missing"); // (RQ1)

    c_boot: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(booting));
    c_dec: cover property (@(posedge sys_clk) disable iff (!nrst)
        st_r == st_run && pc_cmd == pc_dec);
    c_odd: cover property (@(posedge sys_clk) disable iff (!nrst) half_sel_r);
    c_fault: cover property (@(posedge sys_clk) disable iff (!nrst) vec_fault);
endmodule // pmem_addr
`default_nettype wire

// [design/pmem_pkg.sv]
package pmem_pkg;
    // program address width (24-bit program counter, byte-style addressing)
    localparam int unsigned pc_w = 24;
    // stored instruction word width
    localparam int unsigned instr_w = 24;
    // one half of a program word as seen through data-space style access
    localparam int unsigned half_w = 16;
    // implemented bits of the upper half
    localparam int unsigned upper_impl_w = 8;
    // word-index width of the storage array (kept small for the model)
    localparam int unsigned idx_w = 8;
    localparam int unsigned depth = 256;
    // pc step per instruction word
    localparam logic [23:0] pc_step = 24'h000002;
    // hardware reset vector and the word holding the start-of-code target
    localparam logic [23:0] reset_vec = 24'h000000;
    localparam logic [23:0] start_ptr_addr = 24'h000002;
    // top of the reserved vector region (exclusive)
    localparam logic [23:0] vec_top = 24'h000200;
    // jump opcode that the vector word is expected to hold in bits 23:16
    localparam logic [7:0] jump_op = 8'h04;
    localparam logic [23:0] instr_reset = 24'h000000;

    typedef enum logic [1:0] {
        pc_hold,
        pc_inc,
        pc_dec,
        pc_load
    } pc_cmd_t;

    typedef enum {
        st_vec,
        st_target,
        st_run
    } boot_state_t;
endpackage : pmem_pkg

// [design/pmem_store.sv]
`timescale 1ns/1ns
`default_nettype none
module pmem_store
    import pmem_pkg::*;
(
    input wire logic sys_clk,                    // core clock
    input wire logic nrst,                       // async reset, active low
    input wire logic [pmem_pkg::pc_w-1:0] addr,  // program address, byte-style
    input wire logic wr_en,                      // write one whole word
    input wire logic [pmem_pkg::instr_w-1:0] wr_data, // word to write
    output logic [pmem_pkg::instr_w-1:0] rd_word // registered word read
);
    import pmem_pkg::*;

    logic [instr_w-1:0] mem_r [depth];
    logic [instr_w-1:0] mem_nxt [depth];
    logic [instr_w-1:0] rd_nxt;
    logic [idx_w-1:0] idx;

    // (RQ1) word index
    // bit 0 selects the half, so the word index starts at bit 1
    assign idx = addr[idx_w:1];

    always_comb begin
        for (int i = 0; i < depth; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (wr_en) begin
            mem_nxt[idx] = wr_data;
        end
        rd_nxt = mem_r[idx];
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < depth; i++) begin
                mem_r[i] <= instr_reset;
            end
            rd_word <= instr_reset;
        end else begin
            for (int i = 0; i < depth; i++) begin
                mem_r[i] <= mem_nxt[i];
            end
            rd_word <= rd_nxt;
        end
    end
endmodule // pmem_store
`default_nettype wire

// [dv/core_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************
// far-side core model
// ****************
module core_model
    import pmem_pkg::*;
(
    input wire logic sys_clk,                      // core clock
    output var pmem_pkg::pc_cmd_t pc_cmd,          // pc command
    output logic [pmem_pkg::pc_w-1:0] pc_target,   // load target
    output logic [pmem_pkg::pc_w-1:0] half_addr,   // half address
    output logic prog_en,                          // word write strobe
    output logic [pmem_pkg::pc_w-1:0] prog_addr,   // word address
    output logic [pmem_pkg::instr_w-1:0] prog_data // word to write
);
    import pmem_pkg::*;
    initial begin
        pc_cmd = pc_hold;
        pc_target = 24'h0;
        half_addr = 24'h0;
        prog_en = 1'h0;
        prog_addr = 24'h0;
        prog_data = 24'h0;
    end
    // one command per cycle, changed off the sampling edge
    task automatic issue(input pc_cmd_t c, input logic [23:0] v);
        @(negedge sys_clk);
        pc_cmd = c;
        pc_target = v;
        half_addr = v;
    endtask
    // data inverted on release so a stale word cannot pass as held
    task automatic write_word(input logic [23:0] a, input logic [23:0] d);
        @(negedge sys_clk);
        prog_en = 1'h1;
        prog_addr = a;
        prog_data = d;
        @(negedge sys_clk);
        prog_en = 1'h0;
        prog_data = ~d;
    endtask
endmodule // core_model
`default_nettype wire

// [dv/program_memory_addressing_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
// ****************
// bench top
// ****************
module program_memory_addressing_tb;
    import pmem_pkg::*;
    logic sys_clk = 1'h0;
    logic nrst;
    pc_cmd_t pc_cmd;
    logic [pc_w-1:0] pc_target, half_addr, prog_addr, pc;
    logic [instr_w-1:0] prog_data, instr;
    logic [half_w-1:0] half_data;
    logic prog_en, instr_valid, booting, vec_fault;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 sys_clk = ~sys_clk;
    core_model core (.sys_clk(sys_clk), .pc_cmd(pc_cmd), .pc_target(pc_target),
        .half_addr(half_addr), .prog_en(prog_en), .prog_addr(prog_addr),
        .prog_data(prog_data));
    pmem_addr uut (.sys_clk(sys_clk), .nrst(nrst), .pc_cmd(pc_cmd),
        .pc_target(pc_target), .half_addr(half_addr), .prog_en(prog_en),
        .prog_addr(prog_addr), .prog_data(prog_data), .pc(pc), .instr(instr),
        .instr_valid(instr_valid), .booting(booting), .half_data(half_data),
        .vec_fault(vec_fault));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // whole run needs well under a hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 400) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic t_boot();
        nrst = 1'h0;
        repeat (6) @(negedge sys_clk);
        `CHK(pc, reset_vec)
        `CHK(booting, 1'h1)
        `CHK(instr_valid, 1'h0)
        `CHK(vec_fault, 1'h0)
        nrst = 1'h1;
        @(negedge sys_clk);
        `CHK(pc, start_ptr_addr)
        @(negedge sys_clk);
        `CHK(pc, start_ptr_addr)
        `CHK(booting, 1'h1)
        @(negedge sys_clk);
        // cleared storage gives a zero start target
        `CHK(pc, 24'h000000)
        `CHK(booting, 1'h0)
    endtask
    task automatic t_step();
        core.issue(pc_load, 24'h000041);
        core.issue(pc_hold, 24'h000041);
        `CHK(pc, 24'h000040)
        core.issue(pc_inc, 24'h000040);
        core.issue(pc_hold, 24'h000040);
        `CHK(pc, 24'h000040 + pc_step)
        core.issue(pc_dec, 24'h000040);
        core.issue(pc_hold, 24'h000040);
        `CHK(pc, 24'h000040)
        core.issue(pc_hold, 24'h000040);
        `CHK(pc, 24'h000040)
    endtask
    task automatic t_fetch();
        core.write_word(24'h000010, 24'h123456);
        core.write_word(24'h000012, 24'habcdef);
        core.issue(pc_load, 24'h000010);
        core.issue(pc_inc, 24'h000012);
        core.issue(pc_hold, 24'h000012);
        // the flag stands only for the cycle after the fetch edge
        `CHK(vec_fault, 1'h1)
        @(negedge sys_clk);
        `CHK(instr, 24'habcdef)
        `CHK(instr_valid, 1'h1)
        @(negedge sys_clk);
        `CHK(half_data, 16'hcdef)
        core.issue(pc_hold, 24'h000013);
        repeat (2) @(negedge sys_clk);
        `CHK(half_data, 16'h00ab)
        core.issue(pc_load, 24'h000300);
        core.issue(pc_inc, 24'h000302);
        core.issue(pc_hold, 24'h000302);
        @(negedge sys_clk);
        `CHK(pc, 24'h000302)
        `CHK(vec_fault, 1'h0)
    endtask
    initial begin
        t_boot();
        t_step();
        t_fetch();
        // mid-run reset walks the boot sequence again
        t_boot();
        close_out();
    end
endmodule // program_memory_addressing_tb
`default_nettype wire
